// ### frbl_regs.v
// frame buffer length, level and underrun registers of one baseband core
//
// Contract
// - the underrun bit is set while transmitting when the last host write address is below the core read address, and the transmit start command clears it.
// - the fill level is shown as its eight low bits in one register and its three upper bits in another.
// - the received length registers change only on a valid header, are read-only and reset to zero.
// - the receive frame start interrupt is not raised when the decoded length is zero.
// - the received length is 11 bits, upper three in bits 2..0 of the high byte, bits 7..3 reading zero.
// - the transmit length is 11 host-writable bits, only bits 2..0 of its high byte writable, reset zero.
// - a new level threshold takes effect only when its high byte is written; the low byte is staged.
// - the fill level counts octets read by the core from the transmit buffer or stored to the receive buffer.
// - the level interrupt fires once the stored receive octet count exceeds the committed threshold.
`default_nettype none
`include "frbl_defines.vh"

module frbl_regs (
  // clock and reset
  input  wire                      clock,
  input  wire                      rst,
  // host register port
  input  wire [`FRBL_ADDR_W-1:0]   host_addr,
  input  wire                      host_wr_en,
  input  wire [7:0]                host_wdata,
  input  wire                      host_rd_en,
  input  wire                      host_block_start,
  output reg  [7:0]                host_rdata_reg,
  // host writes into the transmit buffer
  input  wire                      host_buf_wr,
  input  wire [`FRBL_LEN_W-1:0]    host_buf_wr_addr,
  // commands
  input  wire                      cmd_tx_start,
  input  wire                      cmd_rx_start,
  input  wire                      tx_active,
  // core transmit buffer reads
  input  wire                      core_tx_rd,
  input  wire [`FRBL_LEN_W-1:0]    core_tx_rd_addr,
  // core receive octets and header
  input  wire                      rx_octet_valid,
  input  wire [7:0]                rx_octet_data,
  output wire                      rx_octet_ready,
  input  wire                      phr_valid,
  input  wire [`FRBL_LEN_W-1:0]    phr_length,
  // receive buffer store port
  output reg                       store_valid_reg,
  output reg  [7:0]                store_data_reg,
  input  wire                      store_ready,
  // values seen by the core
  output reg  [`FRBL_LEN_W-1:0]    tx_length_reg,
  output reg  [7:0]                rx_buffer_first_reg,
  output reg  [7:0]                rx_buffer_last_reg,
  output reg  [7:0]                tx_buffer_first_reg,
  output reg  [7:0]                tx_buffer_last_reg,
  // events
  output reg                       tx_underrun_flag_reg,
  output reg                       rx_frame_start_irq_reg,
  output reg                       level_irq_reg
);

  // state
  reg  [`FRBL_LEN_W-1:0]  buffer_fill_level_reg;
  reg  [`FRBL_LEN_W-1:0]  fill_snap_reg;
  reg  [`FRBL_LEN_W-1:0]  rx_length_reg;
  reg  [7:0]              threshold_low_byte_reg;
  reg  [`FRBL_LEN_W-1:0]  level_irq_threshold_reg;
  reg  [`FRBL_LEN_W-1:0]  spi_addr_reg;
  reg                     spi_addr_neg_reg;
  reg  [`FRBL_LEN_W-1:0]  core_addr_reg;
  reg                     core_seen_reg;
  reg                     rx_mode_reg;
  reg                     level_fired_reg;

  // fifo draining side
  wire                    fifo_out_valid;
  wire [7:0]              fifo_out_data;
  wire                    fifo_out_ready;
  wire                    store_done;
  wire                    wr_txlen_low;
  wire                    underrun_set;
  wire [`FRBL_LEN_W-1:0]  fill_inc;

  // a one-entry output stage keeps the store port straight from flops
  assign fifo_out_ready = ~store_valid_reg | store_ready;
  assign store_done     = store_valid_reg & store_ready;
  assign wr_txlen_low   = host_wr_en & (host_addr == `FRBL_IDX_TXLEN_LOW);
  assign fill_inc       = buffer_fill_level_reg + 1'b1;

  // the negative flag, set at reset and after a length low-byte write, stands for host address minus one
  assign underrun_set = tx_active & core_seen_reg &
                        (spi_addr_neg_reg | (spi_addr_reg < core_addr_reg));

  frbl_fifo #(
    .WIDTH (8),
    .DEPTH (`FRBL_FIFO_DEPTH),
    .AW    (`FRBL_FIFO_AW)
  ) u_rx_fifo (
    .clock     (clock),
    .rst       (rst),
    .clear     (cmd_rx_start),
    .in_valid  (rx_octet_valid),
    .in_data   (rx_octet_data),
    .in_ready  (rx_octet_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_out_ready)
  );

  // store stage
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      store_valid_reg <= 1'b0;
      store_data_reg  <= `FRBL_RST_BYTE;
    end else if (cmd_rx_start) begin
      store_valid_reg <= 1'b0;
    end else if (fifo_out_ready) begin
      store_valid_reg <= fifo_out_valid;
      if (fifo_out_valid)
        store_data_reg <= fifo_out_data;
    end
  end

  // host-side tracking of the last transmit buffer write
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      spi_addr_reg     <= {`FRBL_LEN_W{1'b0}};
      spi_addr_neg_reg <= 1'b1;
    end else if (host_buf_wr) begin
      spi_addr_reg     <= host_buf_wr_addr;
      spi_addr_neg_reg <= 1'b0;
    end else if (wr_txlen_low) begin
      spi_addr_neg_reg <= 1'b1;
    end
  end

  // core-side tracking of the last transmit buffer read
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      core_addr_reg <= {`FRBL_LEN_W{1'b0}};
      core_seen_reg <= 1'b0;
    end else if (cmd_tx_start) begin
      core_seen_reg <= 1'b0;
    end else if (core_tx_rd) begin
      core_addr_reg <= core_tx_rd_addr;
      core_seen_reg <= 1'b1;
    end
  end

  // sticky underrun; a set in the same cycle as a clear wins so no event is lost
  always @(posedge clock or posedge rst) begin
    if (rst)
      tx_underrun_flag_reg <= 1'b0;
    else if (underrun_set)
      tx_underrun_flag_reg <= 1'b1;
    else if (cmd_tx_start | wr_txlen_low)
      tx_underrun_flag_reg <= 1'b0;
  end

  // fill level gauge; rx mode counts stores, tx mode counts core reads
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      buffer_fill_level_reg <= {`FRBL_LEN_W{1'b0}};
      rx_mode_reg           <= 1'b0;
    end else if (cmd_rx_start) begin
      buffer_fill_level_reg <= {`FRBL_LEN_W{1'b0}};
      rx_mode_reg           <= 1'b1;
    end else if (cmd_tx_start) begin
      buffer_fill_level_reg <= {`FRBL_LEN_W{1'b0}};
      rx_mode_reg           <= 1'b0;
    end else if (rx_mode_reg ? store_done : core_tx_rd) begin
      buffer_fill_level_reg <= fill_inc;
    end
  end

  // snapshot at the head of a block read keeps both bytes from one count
  always @(posedge clock or posedge rst) begin
    if (rst)
      fill_snap_reg <= {`FRBL_LEN_W{1'b0}};
    else if (host_block_start)
      fill_snap_reg <= buffer_fill_level_reg;
  end

  // received length, only on a valid header
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_length_reg          <= `FRBL_RST_LEN;
      rx_frame_start_irq_reg <= 1'b0;
    end else begin
      rx_frame_start_irq_reg <= 1'b0;
      if (phr_valid) begin
        rx_length_reg          <= phr_length;
        rx_frame_start_irq_reg <= (phr_length != {`FRBL_LEN_W{1'b0}});
      end
    end
  end

  // threshold: low byte staged, committed with the high byte
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      threshold_low_byte_reg  <= `FRBL_RST_BYTE;
      level_irq_threshold_reg <= `FRBL_RST_THR;
    end else if (host_wr_en) begin
      if (host_addr == `FRBL_IDX_THR_LOW)
        threshold_low_byte_reg <= host_wdata;
      if (host_addr == `FRBL_IDX_THR_HIGH)
        level_irq_threshold_reg <= {host_wdata[`FRBL_UPPER_W-1:0],
                                    threshold_low_byte_reg};
    end
  end

  // level interrupt fires once per receive, when the count first exceeds the threshold
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      level_irq_reg   <= 1'b0;
      level_fired_reg <= 1'b0;
    end else begin
      level_irq_reg <= 1'b0;
      if (cmd_rx_start) begin
        level_fired_reg <= 1'b0;
      end else if (rx_mode_reg & store_done & ~level_fired_reg &
                   (fill_inc > level_irq_threshold_reg)) begin
        level_irq_reg   <= 1'b1;
        level_fired_reg <= 1'b1;
      end
    end
  end

  // host-writable configuration
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_length_reg       <= `FRBL_RST_LEN;
      rx_buffer_first_reg <= `FRBL_RST_BYTE;
      rx_buffer_last_reg  <= `FRBL_RST_BYTE;
      tx_buffer_first_reg <= `FRBL_RST_BYTE;
      tx_buffer_last_reg  <= `FRBL_RST_BYTE;
    end else if (host_wr_en) begin
      case (host_addr)
        `FRBL_IDX_TXLEN_HIGH:
          tx_length_reg[`FRBL_LEN_W-1:8] <= host_wdata[`FRBL_UPPER_W-1:0];
        `FRBL_IDX_TXLEN_LOW:
          tx_length_reg[7:0] <= host_wdata;
        `FRBL_IDX_RXBUF_FIRST:
          rx_buffer_first_reg <= host_wdata;
        `FRBL_IDX_RXBUF_LAST:
          rx_buffer_last_reg <= host_wdata;
        `FRBL_IDX_TXBUF_FIRST:
          tx_buffer_first_reg <= host_wdata;
        `FRBL_IDX_TXBUF_LAST:
          tx_buffer_last_reg <= host_wdata;
        default: begin
        end
      endcase
    end
  end

  // read mux, registered; upper bytes pad with zeros
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      host_rdata_reg <= `FRBL_RST_BYTE;
    end else if (host_rd_en) begin
      case (host_addr)
        `FRBL_IDX_PHY_STATUS:
          host_rdata_reg <= {7'h00, tx_underrun_flag_reg};
        `FRBL_IDX_FILL_LOW:
          host_rdata_reg <= fill_snap_reg[7:0];
        `FRBL_IDX_FILL_HIGH:
          host_rdata_reg <= {5'h00, fill_snap_reg[`FRBL_LEN_W-1:8]};
        `FRBL_IDX_RXLEN_HIGH:
          host_rdata_reg <= {5'h00, rx_length_reg[`FRBL_LEN_W-1:8]};
        `FRBL_IDX_RXLEN_LOW:
          host_rdata_reg <= rx_length_reg[7:0];
        `FRBL_IDX_TXLEN_HIGH:
          host_rdata_reg <= {5'h00, tx_length_reg[`FRBL_LEN_W-1:8]};
        `FRBL_IDX_TXLEN_LOW:
          host_rdata_reg <= tx_length_reg[7:0];
        `FRBL_IDX_RXBUF_FIRST:
          host_rdata_reg <= rx_buffer_first_reg;
        `FRBL_IDX_RXBUF_LAST:
          host_rdata_reg <= rx_buffer_last_reg;
        `FRBL_IDX_TXBUF_FIRST:
          host_rdata_reg <= tx_buffer_first_reg;
        `FRBL_IDX_TXBUF_LAST:
          host_rdata_reg <= tx_buffer_last_reg;
        `FRBL_IDX_THR_LOW:
          host_rdata_reg <= threshold_low_byte_reg;
        `FRBL_IDX_THR_HIGH:
          host_rdata_reg <= {5'h00, level_irq_threshold_reg[`FRBL_LEN_W-1:8]};
        default:
          host_rdata_reg <= `FRBL_UNMAPPED_DATA;
      endcase
    end
  end

endmodule // frbl_regs

`default_nettype wire

// ### frbl_defines.vh
// register indices, field layout, reset values and sizes of the frame buffer length/level block
`ifndef FRBL_DEFINES_VH
`define FRBL_DEFINES_VH

// register indices on the host register port
`define FRBL_ADDR_W            4
`define FRBL_IDX_PHY_STATUS    4'h0
`define FRBL_IDX_FILL_LOW      4'h1
`define FRBL_IDX_FILL_HIGH     4'h2
`define FRBL_IDX_RXLEN_HIGH    4'h3
`define FRBL_IDX_RXLEN_LOW     4'h4
`define FRBL_IDX_TXLEN_HIGH    4'h5
`define FRBL_IDX_TXLEN_LOW     4'h6
`define FRBL_IDX_RXBUF_FIRST   4'h7
`define FRBL_IDX_RXBUF_LAST    4'h8
`define FRBL_IDX_TXBUF_FIRST   4'h9
`define FRBL_IDX_TXBUF_LAST    4'ha
`define FRBL_IDX_THR_LOW       4'hb
`define FRBL_IDX_THR_HIGH      4'hc

// field layout
`define FRBL_LEN_W             11
`define FRBL_UPPER_W           3
`define FRBL_UNDERRUN_BIT      0

// reset values
`define FRBL_RST_BYTE          8'h00
`define FRBL_RST_LEN           11'h000
`define FRBL_RST_THR           11'h000

// answer to an unmapped index
`define FRBL_UNMAPPED_DATA     8'h00

// octet fifo in the receive store path
`define FRBL_FIFO_DEPTH        4
`define FRBL_FIFO_AW           2

`endif

// ### frbl_fifo.v
// small parameterised fifo with valid/ready on both sides and registered flags
`default_nettype none

module frbl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             clock,
  input  wire             rst,
  input  wire             clear,
  // filling side
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output reg              in_ready,
  // draining side
  output reg              out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_reg;
  reg  [AW-1:0]    rd_ptr_reg;
  reg  [AW:0]      count_reg;
  reg  [AW:0]      count_next;
  wire             push;
  wire             pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rd_ptr_reg];

  always @* begin
    count_next = count_reg;
    if (push & ~pop)
      count_next = count_reg + 1'b1;
    else if (pop & ~push)
      count_next = count_reg - 1'b1;
  end

  always @(posedge clock) begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  // flags come from flops so neither side sees a combinational path through the other
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      in_ready   <= 1'b0;
      out_valid  <= 1'b0;
    end else if (clear) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      in_ready   <= 1'b1;
      out_valid  <= 1'b0;
    end else begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      in_ready  <= (count_next != DEPTH[AW:0]);
      out_valid <= (count_next != {(AW+1){1'b0}});
    end
  end

endmodule // frbl_fifo

`default_nettype wire

// ### frbl_regs_monitor.sv
// assertion checker for the frame buffer length and level registers
`default_nettype none
`include "frbl_defines.vh"
module frbl_regs_monitor (
  // clock and reset
  input wire logic                    clock,
  input wire logic                    rst,
  // host register port
  input wire logic [`FRBL_ADDR_W-1:0] host_addr,
  input wire logic                    host_wr_en,
  input wire logic [7:0]              host_wdata,
  input wire logic                    host_rd_en,
  input wire logic [7:0]              host_rdata_reg,
  // core side
  input wire logic                    cmd_tx_start,
  input wire logic                    cmd_rx_start,
  input wire logic                    tx_active,
  input wire logic                    phr_valid,
  input wire logic [`FRBL_LEN_W-1:0]  phr_length,
  input wire logic                    store_valid_reg,
  input wire logic [7:0]              store_data_reg,
  input wire logic                    store_ready,
  input wire logic [`FRBL_LEN_W-1:0]  tx_length_reg,
  input wire logic                    tx_underrun_flag_reg,
  input wire logic                    rx_frame_start_irq_reg,
  input wire logic                    level_irq_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire       wr_txl = host_wr_en && host_addr == `FRBL_IDX_TXLEN_LOW;
  logic [7:0] wd_q;
  logic      hs_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wd_q <= 8'h00;
      hs_q <= 1'b0;
    end else begin
      wd_q <= host_wdata;
      hs_q <= store_valid_reg && store_ready;
    end
  end
  a_len_zero_quiet: assert property (phr_valid && phr_length == 11'h000 |=>
    !rx_frame_start_irq_reg) else $error("frame start irq on zero length");
  a_hdr_gives_irq: assert property (phr_valid && phr_length != 11'h000 |=>
    rx_frame_start_irq_reg) else $error("no frame start irq after header");
  a_irq_has_hdr: assert property (rx_frame_start_irq_reg |-> $past(phr_valid))
    else $error("frame start irq without header");
  a_txlen_low_wr: assert property (wr_txl |=> tx_length_reg[7:0] == wd_q)
    else $error("tx length low byte not written");
  a_txlen_high_wr: assert property (host_wr_en && host_addr == `FRBL_IDX_TXLEN_HIGH
    |=> tx_length_reg[10:8] == wd_q[2:0]) else $error("tx length high bits not written");
  a_upper_bits_zero: assert property (host_rd_en && (host_addr == `FRBL_IDX_RXLEN_HIGH
    || host_addr == `FRBL_IDX_TXLEN_HIGH || host_addr == `FRBL_IDX_FILL_HIGH)
    |=> host_rdata_reg[7:3] == 5'h00) else $error("high byte upper bits not zero");
  a_underrun_sticky: assert property (tx_underrun_flag_reg && !cmd_tx_start && !wr_txl
    |=> tx_underrun_flag_reg) else $error("underrun flag dropped");
  a_underrun_clears: assert property (cmd_tx_start && !tx_active |=>
    !tx_underrun_flag_reg) else $error("underrun flag not cleared by tx start");
  a_store_holds: assert property (store_valid_reg && !store_ready && !cmd_rx_start
    |=> store_valid_reg && $stable(store_data_reg)) else $error("store octet not held");
  a_lvl_from_store: assert property (level_irq_reg |-> hs_q)
    else $error("level irq without store handshake");
  a_lvl_one_pulse: assert property (level_irq_reg |=> !level_irq_reg)
    else $error("level irq longer than one cycle");
  c_level_irq: cover property (level_irq_reg);
  c_underrun: cover property (tx_underrun_flag_reg);
  c_store_stall: cover property (store_valid_reg && !store_ready);
endmodule // frbl_regs_monitor
bind frbl_regs frbl_regs_monitor i_frbl_regs_monitor (.clock, .rst, .host_addr, .host_wr_en,
  .host_wdata, .host_rd_en, .host_rdata_reg, .cmd_tx_start, .cmd_rx_start, .tx_active,
  .phr_valid, .phr_length, .store_valid_reg, .store_data_reg, .store_ready, .tx_length_reg,
  .tx_underrun_flag_reg, .rx_frame_start_irq_reg, .level_irq_reg);
`default_nettype wire

// ### frbl_store_sink.sv
// receive buffer model taking stored octets, promptly or with long stalls
`default_nettype none
module frbl_store_sink (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // store port
  input  wire logic       valid,
  input  wire logic [7:0] data,
  output var  logic       ready,
  // control and record
  input  wire logic       slow,
  output var  logic [3:0] cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph;
  logic [7:0] mem [0:15];
  // one ready cycle in eight when slow, long enough to back the fifo up
  always @(negedge clock or posedge rst) begin
    if (rst) begin
      ph <= 3'h0;
      ready <= 1'b0;
    end else begin
      ph <= ph + 3'h1;
      ready <= !slow || ph == 3'h0;
    end
  end
  always @(posedge clock or posedge rst) begin
    if (rst) cnt <= 4'h0;
    else if (valid && ready) begin
      mem[cnt] <= data;
      cnt <= cnt + 4'h1;
    end
  end
endmodule // frbl_store_sink
`default_nettype wire

// ### frbl_regs_bench.sv
// self-checking bench for the frame buffer length and level registers
`default_nettype none
`include "frbl_defines.vh"
module frbl_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, host_wr_en = 0, host_rd_en = 0, host_block_start = 0;
  logic host_buf_wr = 0, cmd_tx_start = 0, cmd_rx_start = 0, tx_active = 0, core_tx_rd = 0;
  logic rx_octet_valid = 0, phr_valid = 0, slow = 0;
  logic [3:0] host_addr = 0, sink_cnt;
  logic [7:0] host_wdata = 0, rx_octet_data = 0, host_rdata_reg, store_data_reg, b;
  logic [10:0] host_buf_wr_addr = 0, core_tx_rd_addr = 0, phr_length = 0, tx_length_reg, f, w;
  logic rx_octet_ready, store_valid_reg, store_ready, tx_underrun_flag_reg;
  logic rx_frame_start_irq_reg, level_irq_reg;
  logic [7:0] rxf, rxl, txf, txl;
  logic [15:0] rxirq_n = 0, lvl_n = 0, stall_n = 0, n0;
  logic [31:0] seed = 32'h09e24ad0;
  logic [7:0] exp_q [0:7];
  int error_cnt = 0, compares = 0, i;
  frbl_regs i_frbl_regs (.clock, .rst, .host_addr, .host_wr_en, .host_wdata, .host_rd_en,
    .host_block_start, .host_rdata_reg, .host_buf_wr, .host_buf_wr_addr, .cmd_tx_start,
    .cmd_rx_start, .tx_active, .core_tx_rd, .core_tx_rd_addr, .rx_octet_valid,
    .rx_octet_data, .rx_octet_ready, .phr_valid, .phr_length, .store_valid_reg,
    .store_data_reg, .store_ready, .tx_length_reg, .rx_buffer_first_reg(rxf),
    .rx_buffer_last_reg(rxl), .tx_buffer_first_reg(txf), .tx_buffer_last_reg(txl),
    .tx_underrun_flag_reg, .rx_frame_start_irq_reg, .level_irq_reg);
  frbl_store_sink i_frbl_store_sink (.clock, .rst, .valid(store_valid_reg),
    .data(store_data_reg), .ready(store_ready), .slow, .cnt(sink_cnt));
  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (rx_frame_start_irq_reg) rxirq_n <= rxirq_n + 16'h1;
    if (level_irq_reg) lvl_n <= lvl_n + 16'h1;
    if (rx_octet_valid && !rx_octet_ready) stall_n <= stall_n + 16'h1;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [3:0] a, input logic [7:0] d);
    if (a == `FRBL_IDX_RXLEN_HIGH || a == `FRBL_IDX_RXLEN_LOW) return 8'h00;
    if (a == `FRBL_IDX_TXLEN_HIGH) return {5'h00, d[2:0]};
    return d;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    host_addr = a;
    host_wdata = d;
    host_wr_en = 1;
    @(negedge clock);
    host_wr_en = 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clock);
    host_addr = a;
    host_rd_en = 1;
    @(negedge clock);
    host_rd_en = 0;
    d = host_rdata_reg;
  endtask
  task automatic rdfill(output logic [10:0] v);
    logic [7:0] lo, hi;
    @(negedge clock);
    host_block_start = 1;
    @(negedge clock);
    host_block_start = 0;
    rd(`FRBL_IDX_FILL_LOW, lo);
    rd(`FRBL_IDX_FILL_HIGH, hi);
    v = {hi[2:0], lo};
  endtask
  task automatic cmd(input logic tx);
    @(negedge clock);
    if (tx) cmd_tx_start = 1;
    else cmd_rx_start = 1;
    @(negedge clock);
    cmd_tx_start = 0;
    cmd_rx_start = 0;
  endtask
  task automatic core(input logic [10:0] a);
    @(negedge clock);
    core_tx_rd = 1;
    core_tx_rd_addr = a;
    @(negedge clock);
    core_tx_rd = 0;
  endtask
  task automatic send(input logic [7:0] d);
    int n;
    @(negedge clock);
    rx_octet_data = d;
    rx_octet_valid = 1;
    n = 0;
    while (!rx_octet_ready && n < 100) begin
      @(negedge clock);
      n++;
    end
    if (n == 100) error_cnt++;
    @(negedge clock);
    rx_octet_valid = 0;
  endtask
  task automatic wait_cnt(input logic [3:0] e);
    int n;
    n = 0;
    while (sink_cnt != e && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (n == 200) error_cnt++;
    repeat (2) @(negedge clock);
  endtask
  task automatic results;
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    results;
  end
  initial begin
    repeat (6) @(negedge clock);
    rst = 0;
    for (i = 0; i < 14; i++) begin
      rd(i[3:0], b);
      chk(b, 16'h0000);
    end
    for (i = 3; i < 12; i++) begin
      seed = lfsr(seed);
      wr(i[3:0], seed[7:0]);
      rd(i[3:0], b);
      chk(b, exp_rd(i[3:0], seed[7:0]));
      if (i == 5) w = {seed[2:0], 8'h00};
      if (i == 6) chk(tx_length_reg, {w[10:8], seed[7:0]});
      if (i > 6 && i < 11) chk(i == 7 ? rxf : i == 8 ? rxl : i == 9 ? txf : txl, seed[7:0]);
    end
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      w = i == 0 ? (seed[10:0] | 11'h001) : (i == 1 ? 11'h7ff : 11'h000);
      n0 = rxirq_n;
      @(negedge clock);
      phr_length = w;
      phr_valid = 1;
      @(negedge clock);
      phr_valid = 0;
      rd(`FRBL_IDX_RXLEN_LOW, b);
      chk(b, w[7:0]);
      rd(`FRBL_IDX_RXLEN_HIGH, b);
      chk(b, {5'h00, w[10:8]});
      chk(rxirq_n - n0, {15'h0000, w != 11'h000});
    end
    // low byte left staged: a commit here would fire the irq at once
    wr(`FRBL_IDX_THR_LOW, 8'h06);
    wr(`FRBL_IDX_THR_HIGH, 8'h00);
    wr(`FRBL_IDX_THR_LOW, 8'h00);
    slow = 1;
    cmd(1'b0);
    fork
      for (i = 0; i < 8; i++) begin
        seed = lfsr(seed);
        exp_q[i] = seed[7:0];
        send(seed[7:0]);
      end
      begin
        wait_cnt(4'h6);
        chk(lvl_n, 16'h0000);
      end
    join
    wait_cnt(4'h8);
    chk(lvl_n, 16'h0001);
    chk({15'h0000, stall_n != 16'h0}, 16'h0001);
    rdfill(f);
    chk(f, 16'h0008);
    for (i = 0; i < 8; i++) chk(i_frbl_store_sink.mem[i], exp_q[i]);
    seed = lfsr(seed);
    w = {1'b0, seed[9:0]} + 11'h004;
    wr(`FRBL_IDX_TXLEN_LOW, seed[7:0]);
    cmd(1'b1);
    tx_active = 1;
    @(negedge clock);
    host_buf_wr = 1;
    host_buf_wr_addr = w;
    @(negedge clock);
    host_buf_wr = 0;
    core(w - 11'h003);
    core(w);
    rd(`FRBL_IDX_PHY_STATUS, b);
    chk(b, 16'h0000);
    core(w + 11'h001);
    rd(`FRBL_IDX_PHY_STATUS, b);
    chk(b, 16'h0001);
    chk(tx_underrun_flag_reg, 16'h0001);
    rdfill(f);
    chk(f, 16'h0003);
    tx_active = 0;
    cmd(1'b1);
    rd(`FRBL_IDX_PHY_STATUS, b);
    chk(b, 16'h0000);
    results;
  end
endmodule // frbl_regs_bench
`default_nettype wire
